// ==== degauss_pkg.sv ====
package degauss_pkg;
    // ------------------------------------------------------------
    // clock and timing constants
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100; // system clock rate in MHz
    localparam int OVR_SUPPRESS_NS = 3000; // overload suppression time
    localparam int OVR_SUPPRESS_CYC = OVR_SUPPRESS_NS * CLK_MHZ / 1000;
    localparam int DEMAG_ON_NS = 25600; // request high qualification
    localparam int DEMAG_ON_CYC = DEMAG_ON_NS * CLK_MHZ / 1000;
    localparam int DEMAG_OFF_NS = 25000; // request low abort filter
    localparam int DEMAG_OFF_CYC = DEMAG_OFF_NS * CLK_MHZ / 1000;
    localparam int DEMAG_CYCLE_US = 110000; // degauss cycle length
    localparam int DEMAG_CYCLE_CYC = DEMAG_CYCLE_US * CLK_MHZ;
    localparam int ABORT_HOLD_US = 3300; // hold-off after abort or recovery
    localparam int ABORT_HOLD_CYC = ABORT_HOLD_US * CLK_MHZ;
    localparam int PON_DEMAG_NS = 12000; // power-on to degauss start
    localparam int PON_DEMAG_CYC = PON_DEMAG_NS * CLK_MHZ / 1000;
    localparam int PON_RUN_NS = 32000; // power-on to normal start
    localparam int PON_RUN_CYC = PON_RUN_NS * CLK_MHZ / 1000;
    localparam int HALF_MAX_NS = 32000; // longest probe half-period
    localparam int HALF_MAX_CYC = HALF_MAX_NS * CLK_MHZ / 1000;
    localparam int HALF_MIN_NS = 280; // shortest probe half-period
    localparam int HALF_MIN_CYC = (HALF_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SUPPLY_DIP_NS = 31000; // supply dips ignored below this
    localparam int SUPPLY_DIP_CYC = SUPPLY_DIP_NS * CLK_MHZ / 1000;
    localparam int BROWNOUT_NS = 100000; // brown-out to power-on reset
    localparam int BROWNOUT_CYC = BROWNOUT_NS * CLK_MHZ / 1000;
    localparam int GOOD_HALVES = 8; // four full probe cycles
    localparam int CNT_W = 24; // width of interval counters

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_PON_WAIT,
        ST_DEMAG,
        ST_HOLD,
        ST_QUALIFY,
        ST_RUN
    } seq_state_t;
endpackage : degauss_pkg

// ==== level_filter.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// level filter: out follows in once in has held for LEN cycles
// ------------------------------------------------------------
module level_filter #(
    parameter int LEN = 4,
    parameter int W = 24
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    // data
    input wire logic lvl_in,
    output logic lvl_out
);
    logic [W-1:0] cnt_ff; // cycles since last change
    logic out_ff; // filtered level

    // count stable cycles, flip output after LEN of them
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            out_ff <= 1'b0;
        end else if (ce) begin
            if (lvl_in == out_ff) begin
                cnt_ff <= '0;
            end else if (cnt_ff >= W'(LEN - 1)) begin
                cnt_ff <= '0;
                out_ff <= lvl_in;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    assign lvl_out = out_ff;
endmodule : level_filter

// ==== degauss_power_on_sequencer.sv ====
`timescale 1ns/10ps
module degauss_power_on_sequencer
    import degauss_pkg::*;
#(
    parameter int DEMAG_CYCLE_LEN = degauss_pkg::DEMAG_CYCLE_CYC,
    parameter int ABORT_HOLD_LEN = degauss_pkg::ABORT_HOLD_CYC,
    parameter int BROWNOUT_LEN = degauss_pkg::BROWNOUT_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    // supply comparators, high while rail is above the level
    input wire logic rail_above_4v,
    input wire logic rail_above_1v8,
    // probe comparator and amplifier overload
    input wire logic probe_cmp,
    input wire logic amp_nonlinear,
    // degauss request from the controller
    input wire logic demag_req,
    // open-drain range overload flag
    output logic range_flag_o,
    output logic range_flag_oe,
    // open-drain error flag
    output logic error_flag_o,
    output logic error_flag_oe,
    // coil driver and degauss status
    output logic coil_drive_output,
    output logic demag_active,
    output logic probe_run
);
    import degauss_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    seq_state_t state_ff; // sequencer state
    logic [CNT_W-1:0] ovr_cnt_ff; // overload persistence counter
    logic range_ff; // range flag active
    logic [CNT_W-1:0] seq_cnt_ff; // sequence timer
    logic [CNT_W-1:0] half_cnt_ff; // current probe half-period
    logic [CNT_W-1:0] bo_cnt_ff; // brown-out duration
    logic [3:0] good_ff; // good half-periods counted
    logic probe_q_ff; // previous probe level
    logic probe_lost_ff; // oscillation missing
    logic loop_broken_ff; // probe loop interrupted since run
    logic error_ff; // error flag active
    logic coil_ff; // coil driver enabled
    logic req_on; // request held 25.6 us
    logic req_off; // request held low 25 us inside degauss
    logic [CNT_W-1:0] off_cnt_ff; // low request samples during degauss
    logic req_q_ff; // previous qualified request level
    logic req_pend_ff; // fresh qualified request waiting for run
    logic dip_long; // supply dip past 31 us
    logic por; // power-on reset request
    logic probe_edge; // probe comparator toggled
    logic half_short; // edge came too early

    // ------------------------------------------------------------
    // request and supply filters
    // ------------------------------------------------------------
    // rising filter on request
    level_filter #(.LEN(DEMAG_ON_CYC), .W(CNT_W)) u_req_on (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
        .lvl_in(demag_req), .lvl_out(req_on)
    );
    // abort filter: counts low request samples only while degauss runs, so
    // a low level that went stale before the cycle can never cut it short
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            off_cnt_ff <= '0;
        end else if (ce) begin
            if (demag_req || state_ff != ST_DEMAG) begin
                off_cnt_ff <= '0;
            end else if (!req_off) begin
                off_cnt_ff <= off_cnt_ff + 1'b1;
            end
        end
    end

    assign req_off = !demag_req && (off_cnt_ff >= CNT_W'(DEMAG_OFF_CYC - 1));

    // a qualified request arms one degauss; a level held high never retriggers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_q_ff <= 1'b0;
            req_pend_ff <= 1'b0;
        end else if (ce) begin
            req_q_ff <= req_on;
            if (req_on && !req_q_ff && state_ff != ST_DEMAG) begin
                req_pend_ff <= 1'b1;
            end else if (!req_on || state_ff == ST_DEMAG) begin
                req_pend_ff <= 1'b0;
            end
        end
    end

    // supply dip filter for probe supply adequacy
    level_filter #(.LEN(SUPPLY_DIP_CYC), .W(CNT_W)) u_dip (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
        .lvl_in(!rail_above_4v), .lvl_out(dip_long)
    );

    // ------------------------------------------------------------
    // over-range flag
    // ------------------------------------------------------------
    // count overload cycles, assert after 3 us, drop at once
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ovr_cnt_ff <= '0;
            range_ff <= 1'b0;
        end else if (ce) begin
            if (!amp_nonlinear) begin
                ovr_cnt_ff <= '0;
                range_ff <= 1'b0;
            end else if (ovr_cnt_ff >= CNT_W'(OVR_SUPPRESS_CYC - 1)) begin
                range_ff <= 1'b1;
            end else begin
                ovr_cnt_ff <= ovr_cnt_ff + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // probe oscillation monitor
    // ------------------------------------------------------------
    assign probe_edge = probe_cmp != probe_q_ff;
    assign half_short = probe_edge && (half_cnt_ff < CNT_W'(HALF_MIN_CYC - 1));

    // measure half-periods, count good ones, flag lost oscillation
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            probe_q_ff <= 1'b0;
            half_cnt_ff <= '0;
            good_ff <= '0;
            probe_lost_ff <= 1'b0;
        end else if (ce) begin
            probe_q_ff <= probe_cmp;
            if (state_ff == ST_OFF || state_ff == ST_PON_WAIT) begin
                half_cnt_ff <= '0;
                good_ff <= '0;
                probe_lost_ff <= 1'b0;
            end else if (probe_edge) begin
                half_cnt_ff <= '0;
                probe_lost_ff <= 1'b0;
                if (half_short) begin
                    good_ff <= '0;
                end else if (good_ff < 4'(GOOD_HALVES)) begin
                    good_ff <= good_ff + 1'b1;
                end
            end else if (half_cnt_ff >= CNT_W'(HALF_MAX_CYC - 1)) begin
                probe_lost_ff <= 1'b1;
                good_ff <= '0;
            end else begin
                half_cnt_ff <= half_cnt_ff + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // brown-out and power-on reset
    // ------------------------------------------------------------
    assign por = !rail_above_1v8 || (bo_cnt_ff >= CNT_W'(BROWNOUT_LEN - 1));

    // time how long the rail stays below 4V
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bo_cnt_ff <= '0;
        end else if (ce) begin
            if (rail_above_4v || state_ff == ST_OFF) begin
                bo_cnt_ff <= '0;
            end else if (!por) begin
                bo_cnt_ff <= bo_cnt_ff + 1'b1;
            end
        end
    end

    // remember a probe loop break so loop recovery goes the long way through hold-off
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            loop_broken_ff <= 1'b0;
        end else if (ce) begin
            if (state_ff != ST_RUN) begin
                loop_broken_ff <= 1'b0;
            end else if (probe_lost_ff || (dip_long && half_short)) begin
                loop_broken_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // power-on, degauss, hold-off, qualification and run
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_OFF;
            seq_cnt_ff <= '0;
        end else if (ce) begin
            if (por && state_ff != ST_OFF) begin
                state_ff <= ST_OFF;
                seq_cnt_ff <= '0;
            end else begin
                case (state_ff)
                    ST_OFF: begin
                        seq_cnt_ff <= '0;
                        if (rail_above_4v && rail_above_1v8) begin
                            state_ff <= ST_PON_WAIT;
                        end
                    end
                    ST_PON_WAIT: begin
                        seq_cnt_ff <= seq_cnt_ff + 1'b1;
                        if (demag_req && seq_cnt_ff >= CNT_W'(PON_DEMAG_CYC - 1)) begin
                            state_ff <= ST_DEMAG;
                            seq_cnt_ff <= '0;
                        end else if (seq_cnt_ff >= CNT_W'(PON_RUN_CYC - 1)) begin
                            state_ff <= ST_QUALIFY;
                            seq_cnt_ff <= '0;
                        end
                    end
                    ST_DEMAG: begin
                        seq_cnt_ff <= seq_cnt_ff + 1'b1;
                        if (req_off) begin
                            state_ff <= ST_HOLD;
                            seq_cnt_ff <= '0;
                        end else if (seq_cnt_ff >= CNT_W'(DEMAG_CYCLE_LEN - 1)) begin
                            state_ff <= ST_QUALIFY;
                            seq_cnt_ff <= '0;
                        end
                    end
                    ST_HOLD: begin
                        seq_cnt_ff <= seq_cnt_ff + 1'b1;
                        if (seq_cnt_ff >= CNT_W'(ABORT_HOLD_LEN - 1)) begin
                            state_ff <= ST_QUALIFY;
                            seq_cnt_ff <= '0;
                        end
                    end
                    ST_QUALIFY: begin
                        seq_cnt_ff <= '0;
                        if (good_ff >= 4'(GOOD_HALVES)) begin
                            state_ff <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        seq_cnt_ff <= '0;
                        if (req_pend_ff) begin
                            state_ff <= ST_DEMAG;
                        end else if (probe_lost_ff || loop_broken_ff) begin
                            state_ff <= ST_HOLD;
                        end
                    end
                    default: begin
                        state_ff <= ST_OFF;
                        seq_cnt_ff <= '0;
                    end
                endcase
            end
        end
    end

    // error flag and coil driver follow the sequencer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            error_ff <= 1'b1;
            coil_ff <= 1'b0;
        end else if (ce) begin
            error_ff <= (state_ff != ST_RUN) || probe_lost_ff;
            coil_ff <= (state_ff == ST_RUN) && !probe_lost_ff;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign range_flag_o = 1'b0;
    assign range_flag_oe = range_ff;
    assign error_flag_o = 1'b0;
    assign error_flag_oe = error_ff;
    assign coil_drive_output = coil_ff;
    assign demag_active = (state_ff == ST_DEMAG);
    assign probe_run = (state_ff != ST_OFF);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_range_delay;
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(range_ff) |-> $past(amp_nonlinear, 2);
    endproperty
    a_range_delay: assert property (p_range_delay) else $error("range flag too early");

    property p_range_release;
        @(posedge clk_sys) disable iff (!arst_n)
        (ce && !amp_nonlinear) |=> !range_ff;
    endproperty
    a_range_release: assert property (p_range_release) else $error("range flag held");

    property p_demag_error;
        @(posedge clk_sys) disable iff (!arst_n)
        (ce && state_ff == ST_DEMAG) |=> error_ff;
    endproperty
    a_demag_error: assert property (p_demag_error) else $error("error clear in degauss");

    property p_abort_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        (state_ff == ST_DEMAG ##1 state_ff == ST_HOLD) |-> !coil_drive_output [*8];
    endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("coil on after abort");

    property p_coil_run;
        @(posedge clk_sys) disable iff (!arst_n)
        coil_ff |-> !error_ff;
    endproperty
    a_coil_run: assert property (p_coil_run) else $error("coil on with error");

    property p_por_low;
        @(posedge clk_sys) disable iff (!arst_n)
        (ce && !rail_above_1v8) |=> state_ff == ST_OFF;
    endproperty
    a_por_low: assert property (p_por_low) else $error("no reset at low rail");

    property p_qual_good;
        @(posedge clk_sys) disable iff (!arst_n)
        (state_ff == ST_QUALIFY ##1 state_ff == ST_RUN) |-> $past(good_ff) >= 4'(GOOD_HALVES);
    endproperty
    a_qual_good: assert property (p_qual_good) else $error("run without good cycles");

    property p_lost_error;
        @(posedge clk_sys) disable iff (!arst_n)
        (ce && probe_lost_ff) |=> error_ff;
    endproperty
    a_lost_error: assert property (p_lost_error) else $error("lost probe not flagged");

    c_demag: cover property (@(posedge clk_sys) disable iff (!arst_n) state_ff == ST_DEMAG);
    c_abort: cover property (@(posedge clk_sys) disable iff (!arst_n)
        state_ff == ST_DEMAG ##1 state_ff == ST_HOLD);
    c_run: cover property (@(posedge clk_sys) disable iff (!arst_n) state_ff == ST_RUN);
    c_range: cover property (@(posedge clk_sys) disable iff (!arst_n) range_ff);
endmodule : degauss_power_on_sequencer

// ==== controller_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// far side: system controller, probe comparator, pull-ups
// ------------------------------------------------------------
module controller_model #(
    parameter int HALF = 50 // probe half-period in cycles
) (
    // clock
    input wire logic clk_sys,
    // commands from the bench
    input wire logic probe_en,
    input wire logic req_cmd,
    // open-drain flags from the device
    input wire logic range_flag_o,
    input wire logic range_flag_oe,
    input wire logic error_flag_o,
    input wire logic error_flag_oe,
    // lines seen by the device and by the controller
    output logic probe_cmp,
    output logic demag_req,
    output logic range_pin,
    output logic error_pin
);
    int half_cnt; // cycles into the current probe half-period

    // request level follows req_cmd; held low through power-up it skips degauss
    assign demag_req = req_cmd;

    // pull-up resistors: pin high unless the device pulls it low
    assign range_pin = range_flag_oe ? range_flag_o : 1'b1;
    assign error_pin = error_flag_oe ? error_flag_o : 1'b1;

    // probe comparator toggles while oscillating, stays low when stopped
    initial begin
        probe_cmp = 1'b0;
        half_cnt = 0;
        forever begin
            @(posedge clk_sys);
            #1;
            if (!probe_en) begin
                probe_cmp = 1'b0;
                half_cnt = 0;
            end else if (half_cnt == HALF - 1) begin
                probe_cmp = ~probe_cmp;
                half_cnt = 0;
            end else begin
                half_cnt++;
            end
        end
    end
endmodule : controller_model

// ==== tb.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// testbench for the degauss and power-on sequencer
// ------------------------------------------------------------
module tb;
    import degauss_pkg::*;
    localparam int CYC_LEN = 6000; // shortened degauss cycle
    localparam int HOLD_LEN = 100; // shortened hold-off
    localparam int BO_LEN = 500; // shortened brown-out limit
    logic clk_sys, arst_n, rail_above_4v, rail_above_1v8, amp_nonlinear;
    logic probe_en, req_cmd, probe_cmp, demag_req, range_pin, error_pin;
    logic range_flag_o, range_flag_oe, error_flag_o, error_flag_oe;
    logic coil_drive_output, demag_active, probe_run, ce;
    int err_count, checks_done, n;

    // ------------------------------------------------------------
    // device and far side
    // ------------------------------------------------------------
    degauss_power_on_sequencer #(.DEMAG_CYCLE_LEN(CYC_LEN), .ABORT_HOLD_LEN(HOLD_LEN),
        .BROWNOUT_LEN(BO_LEN)) uut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
        .rail_above_4v(rail_above_4v), .rail_above_1v8(rail_above_1v8),
        .probe_cmp(probe_cmp), .amp_nonlinear(amp_nonlinear), .demag_req(demag_req),
        .range_flag_o(range_flag_o), .range_flag_oe(range_flag_oe),
        .error_flag_o(error_flag_o), .error_flag_oe(error_flag_oe),
        .coil_drive_output(coil_drive_output), .demag_active(demag_active),
        .probe_run(probe_run));
    controller_model #(.HALF(50)) ctl (.clk_sys(clk_sys), .probe_en(probe_en),
        .req_cmd(req_cmd), .range_flag_o(range_flag_o), .range_flag_oe(range_flag_oe),
        .error_flag_o(error_flag_o), .error_flag_oe(error_flag_oe),
        .probe_cmp(probe_cmp), .demag_req(demag_req), .range_pin(range_pin),
        .error_pin(error_pin));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // pick an observed signal by number
    function automatic logic sig(input int s);
        case (s)
            0: return coil_drive_output;
            1: return demag_active;
            2: return probe_run;
            3: return error_pin;
            default: return range_pin;
        endcase
    endfunction

    // advance n edges, landing just after the last one
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick

    // count edges until a signal shows v; a required wait that runs out ends the run
    task automatic wait_for(input int s, input logic v, input int lim, input bit must,
        output int cnt);
        cnt = 0;
        while (sig(s) !== v && cnt < lim) begin
            tick(1);
            cnt++;
        end
        if (must && sig(s) !== v) begin
            err_count++;
            $display("CHECK FAILED at %0t: wait ran out on signal %0d", $time, s);
            give_verdict();
        end
    endtask : wait_for

    // compare a design bit
    task automatic cmp_bit(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : cmp_bit

    // compare an elapsed count against a window
    task automatic cmp_range(input int got, input int lo, input int hi, input string msg);
        checks_done++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s took %0d cycles", $time, msg, got);
        end
    endtask : cmp_range

    // counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        err_count = 0;
        checks_done = 0;
        arst_n = 1'b0;
        rail_above_4v = 1'b0;
        rail_above_1v8 = 1'b0;
        amp_nonlinear = 1'b0;
        probe_en = 1'b1;
        req_cmd = 1'b0;
        ce = 1'b1;
        tick(2);
        arst_n = 1'b1;
        cmp_bit(error_pin, 1'b0, "error flag released at reset");
        // power-on with request low: qualify then run
        rail_above_4v = 1'b1;
        rail_above_1v8 = 1'b1;
        wait_for(0, 1'b1, 5000, 1, n);
        cmp_range(n, PON_RUN_CYC, PON_RUN_CYC + 600, "power-on to coil");
        cmp_bit(error_pin, 1'b1, "error flag still low in run");
        // short overload is suppressed, long one shows after 3 us
        amp_nonlinear = 1'b1;
        wait_for(4, 1'b0, 250, 0, n);
        cmp_range(n, 250, 250, "short overload reached pin");
        amp_nonlinear = 1'b0;
        tick(5);
        // frozen by the clock enable the overload must not be counted
        ce = 1'b0;
        amp_nonlinear = 1'b1;
        tick(400);
        cmp_bit(range_pin, 1'b1, "overload counted while frozen");
        ce = 1'b1;
        wait_for(4, 1'b0, 400, 1, n);
        cmp_range(n, OVR_SUPPRESS_CYC - 1, OVR_SUPPRESS_CYC + 1, "overload flag");
        amp_nonlinear = 1'b0;
        wait_for(4, 1'b1, 3, 1, n);
        cmp_range(n, 0, 2, "overload release");
        // short request pulse ignored, held request starts degauss
        req_cmd = 1'b1;
        wait_for(1, 1'b1, 2000, 0, n);
        cmp_range(n, 2000, 2000, "short request started degauss");
        req_cmd = 1'b0;
        tick(3000);
        req_cmd = 1'b1;
        wait_for(1, 1'b1, 3000, 1, n);
        cmp_range(n, DEMAG_ON_CYC - 2, DEMAG_ON_CYC + 3, "request to degauss");
        tick(5);
        cmp_bit(error_pin, 1'b0, "error flag high in degauss");
        cmp_bit(probe_run, 1'b1, "probe stopped in degauss");
        cmp_bit(coil_drive_output, 1'b0, "coil on in degauss");
        wait_for(1, 1'b0, CYC_LEN + 100, 1, n);
        cmp_range(n, CYC_LEN - 8, CYC_LEN, "degauss length");
        // request still high: no second cycle; a fresh request is then aborted
        wait_for(1, 1'b1, 3000, 0, n);
        cmp_range(n, 3000, 3000, "held request retriggered degauss");
        req_cmd = 1'b0;
        tick(2700);
        req_cmd = 1'b1;
        wait_for(1, 1'b1, 3000, 1, n);
        cmp_range(n, DEMAG_ON_CYC - 2, DEMAG_ON_CYC + 3, "fresh request to degauss");
        req_cmd = 1'b0;
        wait_for(1, 1'b0, 3000, 1, n);
        cmp_range(n, DEMAG_OFF_CYC - 3, DEMAG_OFF_CYC + 3, "abort filter");
        cmp_bit(error_pin, 1'b0, "error flag released at abort");
        wait_for(0, 1'b1, 1500, 1, n);
        cmp_range(n, HOLD_LEN, HOLD_LEN + 900, "abort hold-off");
        // probe stops: error after 32 us, resume through hold-off
        probe_en = 1'b0;
        wait_for(3, 1'b0, 3400, 1, n);
        cmp_range(n, HALF_MAX_CYC - 60, HALF_MAX_CYC + 5, "probe loss to error");
        tick(2);
        cmp_bit(coil_drive_output, 1'b0, "coil on after probe loss");
        probe_en = 1'b1;
        wait_for(0, 1'b1, 1500, 1, n);
        cmp_range(n, HOLD_LEN, HOLD_LEN + 900, "probe loss recovery");
        // short dip with probe running is ignored
        rail_above_4v = 1'b0;
        tick(300);
        rail_above_4v = 1'b1;
        tick(5);
        cmp_bit(error_pin, 1'b1, "short dip raised error");
        cmp_bit(coil_drive_output, 1'b1, "short dip stopped coil");
        // long dip gives full power-on, request high restarts with degauss
        rail_above_4v = 1'b0;
        wait_for(2, 1'b0, BO_LEN + 20, 1, n);
        cmp_range(n, BO_LEN - 5, BO_LEN + 5, "brown-out reset");
        req_cmd = 1'b1;
        rail_above_4v = 1'b1;
        wait_for(1, 1'b1, 1500, 1, n);
        cmp_range(n, PON_DEMAG_CYC - 3, PON_DEMAG_CYC + 3, "power-on degauss");
        tick(5);
        cmp_bit(demag_active, 1'b1, "power-on degauss cut short");
        // deep dip resets at once
        rail_above_1v8 = 1'b0;
        wait_for(2, 1'b0, 5, 1, n);
        cmp_range(n, 0, 3, "deep dip reset");
        cmp_bit(demag_active, 1'b0, "degauss survived deep dip");
        give_verdict();
    end
endmodule : tb
